// >>> include/scc_pkg.sv
// Purpose: Shared constants and types of the static memory controller clock/config block
// Assumes: One system clock; memory clock 0 arrives as a sampled input
// Notes:   Every offset, field position, reset value and count is named here once
package scc_pkg;
	// Reset release and crossing depths
	localparam int unsigned RST_SYNC_STAGES = 2;
	localparam int unsigned CDC_STAGES      = 2;

	// Memory access length in memory clock ticks
	localparam logic [3:0] MEM_ACCESS_TICKS = 4'h4;

	// Direct command kind that a NAND interface honours
	localparam logic [1:0] NAND_CMD_TYPE = 2'h2;

	// Operating configuration word: width field position
	localparam int unsigned OPM_W       = 8;
	localparam int unsigned OPM_MW_LSB  = 0;
	localparam int unsigned OPM_MW_W    = 2;
	localparam logic [7:0]  OPM_RESET   = 8'h00;

	// Memory width codes
	localparam logic [1:0] MW_8    = 2'h0;
	localparam logic [1:0] MW_16   = 2'h1;
	localparam logic [1:0] MW_32   = 2'h2;
	localparam logic [1:0] MW_RSVD = 2'h3;

	// Integration test words: widths, implemented bits, reset value
	localparam int unsigned INT_IN_W          = 10;
	localparam int unsigned INT_OUT_W         = 9;
	localparam logic [9:0]  INT_IN_IMPL_MASK  = 10'h03f;
	localparam logic [8:0]  INT_OUT_IMPL_MASK = 9'h027;
	localparam logic [8:0]  INT_OUT_RESET     = 9'h000;

	// Integration output bit positions
	localparam int unsigned INT_OUT_ACTIVE = 0;
	localparam int unsigned INT_OUT_LP_ACK = 1;
	localparam int unsigned INT_OUT_EBIREQ = 2;
	localparam int unsigned INT_OUT_IRQ0   = 5;

	// Read/write arbitration modes
	typedef enum logic [1:0] {
		ARB_READ_FIRST  = 2'b00,
		ARB_WRITE_FIRST = 2'b01,
		ARB_ROUND_ROBIN = 2'b10,
		ARB_RSVD        = 2'b11
	} scc_arb_t;

	// AXI-side issue state
	typedef enum logic [0:0] {
		AX_IDLE = 1'b0,
		AX_WAIT = 1'b1
	} scc_ax_state_t;

	// Memory-side access state
	typedef enum logic [0:0] {
		MS_IDLE   = 1'b0,
		MS_ACCESS = 1'b1
	} scc_ms_state_t;
endpackage

// >>> include/scc_xfer_if.sv
// Purpose: Carries one toggle event and its bypass control between the two domains
// Assumes: Payload is held stable by the sender until the toggle is answered
// Notes:   The stage modport is the synchroniser, the user modport its owner
`timescale 1ns/1ps
`default_nettype none
interface scc_xfer_if;
	logic lvl;
	logic bypass;
	logic sync_lvl;

	modport stage (input lvl, input bypass, output sync_lvl);
	modport user  (output lvl, output bypass, input sync_lvl);
endinterface
`default_nettype wire

// >>> hw/scc_cdc_stage.sv
// Purpose: Two-flop level synchroniser with a bypass for synchronous clocking
// Assumes: Bypass is a static tie-off
// Notes:   The first flop feeds only the second flop
`timescale 1ns/1ps
`default_nettype none
module scc_cdc_stage (
	// Clock, reset, enable
	input  wire logic      clk_sys,
	input  wire logic      rst_dom,
	input  wire logic      ce,
	// Crossing
	scc_xfer_if.stage      x
);
	logic [scc_pkg::CDC_STAGES-1:0] sync_ff;
	logic [scc_pkg::CDC_STAGES-1:0] nxt_sync;

	// Shift chain; frozen while the enable is low
	always_comb
	begin
		nxt_sync = sync_ff;
		if (ce)
			nxt_sync = {sync_ff[scc_pkg::CDC_STAGES-2:0], x.lvl};
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst_dom)
			sync_ff <= '0;
		else
			sync_ff <= nxt_sync;
	end

	// Synchronous clocks need no settling, so the raw level saves two cycles
	assign x.sync_lvl = x.bypass ? x.lvl : sync_ff[scc_pkg::CDC_STAGES-1];
endmodule
`default_nettype wire

// >>> hw/scc_clock_config.sv
// Purpose: Single-interface clock, reset and configuration core of a static memory controller
// Assumes: Inputs synchronous to clk_sys; memory clock 0 sampled, its rise is a tick
// Notes:   AXI domain and memory domain 0 are the only domains
// Notes on behaviour
// - integration inputs: only bits five..zero exist
// - integration outputs: only bits 2..0, 5
// - reads, writes complete in acceptance order
// - arbitrate between pending reads and writes
// - only AXI and memory-0 domains exist
// - NAND direct command honours kind b10 only
// - NAND pending config: only width matters
// - NAND current config: only width meaningful
// - AXI-side indicator high bypasses AXI synchronisers
// - memory-side indicator high bypasses memory synchronisers
// - AXI-faster indicator: AXI faster and synchronous
// - AXI reset is active low
// - memory reset 0 is active low
// - interface pads carry suffix 0
// - NAND interface width 8 or 16 only
// - one to four selects; 32/64 data
// - only interface-0 signals exist here
`timescale 1ns/1ps
`default_nettype none
module scc_clock_config #(
	parameter int unsigned DATA_W     = 32,
	parameter int unsigned ADDR_W     = 32,
	parameter int unsigned CS_COUNT   = 4,
	parameter bit          IF0_NAND   = 1'b1
) (
	// System clock, reset, enable
	input  wire logic                     clk_sys,
	input  wire logic                     rst,
	input  wire logic                     ce,
	// Domain resets and clocks of interface 0
	input  wire logic                     axi_reset_low,
	input  wire logic                     memory_reset_if0_low,
	input  wire logic                     memory_clock_if0,
	input  wire logic                     memory_clock_if0_inverted,
	// Clocking tie-offs
	input  wire logic                     axi_side_sync_ind_if0,
	input  wire logic                     mem_side_sync_ind_if0,
	input  wire logic                     axi_faster_sync_if0,
	input  wire logic [1:0]               rw_priority,
	// Read request and completion
	input  wire logic                     rd_valid,
	output logic                          rd_ready,
	input  wire logic [ADDR_W-1:0]        rd_addr,
	input  wire logic [1:0]               rd_cs,
	output logic                          rd_done,
	output logic [DATA_W-1:0]             rd_data,
	// Write request and completion
	input  wire logic                     wr_valid,
	output logic                          wr_ready,
	input  wire logic [ADDR_W-1:0]        wr_addr,
	input  wire logic [1:0]               wr_cs,
	input  wire logic [DATA_W-1:0]        wr_data,
	output logic                          wr_done,
	// Direct command and operating configuration
	input  wire logic                     dcmd_valid,
	input  wire logic [1:0]               dcmd_type,
	output logic                          dcmd_issued,
	output logic                          dcmd_ignored,
	input  wire logic                     opmode_load,
	input  wire logic [scc_pkg::OPM_W-1:0] pending_opmode,
	output logic [scc_pkg::OPM_W-1:0]     current_opmode,
	output logic [1:0]                    current_memory_width,
	// Integration test
	input  wire logic                     int_test_en,
	input  wire logic                     int_out_wr,
	input  wire logic [scc_pkg::INT_OUT_W-1:0] int_out_wdata,
	output logic [scc_pkg::INT_OUT_W-1:0] int_out_q,
	output logic [scc_pkg::INT_IN_W-1:0]  int_in_rdata,
	input  wire logic                     lowpower_req,
	input  wire logic                     use_ext_bus,
	input  wire logic                     ext_bus_grant_if0,
	input  wire logic                     ext_bus_backoff_if0,
	// Status and control outputs
	output logic                          activity,
	output logic                          lowpower_ack,
	output logic                          ext_bus_req_if0,
	output logic                          mem_irq_if0,
	output logic                          clock_pair_fault_if0,
	// Memory interface 0 pads
	output logic [CS_COUNT-1:0]           mem_cs_if0,
	output logic                          mem_we_if0,
	output logic [ADDR_W-1:0]             mem_addr_if0,
	output logic [DATA_W-1:0]             mem_wdata_if0,
	input  wire logic [DATA_W-1:0]        mem_rdata_if0
);
	// Reset release pipelines, one per domain
	logic [scc_pkg::RST_SYNC_STAGES-1:0] axi_rel_ff, nxt_axi_rel;
	logic [scc_pkg::RST_SYNC_STAGES-1:0] mem_rel_ff, nxt_mem_rel;
	logic                                axi_rst, mem_rst;

	always_comb
	begin
		nxt_axi_rel = axi_rel_ff;
		nxt_mem_rel = mem_rel_ff;
		if (!axi_reset_low)
			nxt_axi_rel = '0;
		else if (ce)
			nxt_axi_rel = {axi_rel_ff[scc_pkg::RST_SYNC_STAGES-2:0], 1'b1};
		if (!memory_reset_if0_low)
			nxt_mem_rel = '0;
		else if (ce)
			nxt_mem_rel = {mem_rel_ff[scc_pkg::RST_SYNC_STAGES-2:0], 1'b1};
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			axi_rel_ff <= '0;
			mem_rel_ff <= '0;
		end
		else
		begin
			axi_rel_ff <= nxt_axi_rel;
			mem_rel_ff <= nxt_mem_rel;
		end
	end

	assign axi_rst = rst | ~axi_rel_ff[scc_pkg::RST_SYNC_STAGES-1];
	assign mem_rst = rst | ~mem_rel_ff[scc_pkg::RST_SYNC_STAGES-1];

	// Crossings: request toward memory, completion toward AXI
	scc_xfer_if req_x ();
	scc_xfer_if ack_x ();

	scc_cdc_stage u_req_stage (
		.clk_sys (clk_sys),
		.rst_dom (mem_rst),
		.ce      (ce),
		.x       (req_x)
	);

	scc_cdc_stage u_ack_stage (
		.clk_sys (clk_sys),
		.rst_dom (axi_rst),
		.ce      (ce),
		.x       (ack_x)
	);

	// AXI faster and synchronous also skips the AXI-side settling
	assign req_x.bypass = mem_side_sync_ind_if0;
	assign ack_x.bypass = axi_side_sync_ind_if0 | axi_faster_sync_if0;

	// AXI domain state
	scc_pkg::scc_ax_state_t    ax_st_ff, nxt_ax_st;
	logic                      rp_ff, nxt_rp, wp_ff, nxt_wp;
	logic [ADDR_W-1:0]         ra_ff, nxt_ra, wa_ff, nxt_wa;
	logic [1:0]                rc_ff, nxt_rc, wc_ff, nxt_wc;
	logic [DATA_W-1:0]         wd_ff, nxt_wd, rdat_ff, nxt_rdat, mem_rdat_ff, nxt_mem_rdat;
	logic                      req_tgl_ff, nxt_req_tgl, ack_seen_ff, nxt_ack_seen;
	logic                      last_wr_ff, nxt_last_wr, fly_wr_ff, nxt_fly_wr;
	logic                      rdone_ff, nxt_rdone, wdone_ff, nxt_wdone;
	logic                      pick_wr;

	assign rd_ready = ~axi_rst & ~rp_ff;
	assign wr_ready = ~axi_rst & ~wp_ff;

	always_comb
	begin
		unique case (scc_pkg::scc_arb_t'(rw_priority))
			scc_pkg::ARB_READ_FIRST:  pick_wr = wp_ff & ~rp_ff;
			scc_pkg::ARB_WRITE_FIRST: pick_wr = wp_ff;
			scc_pkg::ARB_ROUND_ROBIN: pick_wr = wp_ff & (~rp_ff | ~last_wr_ff);
			default:                  pick_wr = wp_ff & ~rp_ff;
		endcase
	end

	// One access in flight keeps each kind in acceptance order
	always_comb
	begin
		nxt_ax_st = ax_st_ff;
		nxt_rp = rp_ff; nxt_ra = ra_ff; nxt_rc = rc_ff;
		nxt_wp = wp_ff; nxt_wa = wa_ff; nxt_wc = wc_ff; nxt_wd = wd_ff;
		nxt_rdat = rdat_ff;
		nxt_req_tgl = req_tgl_ff;
		nxt_ack_seen = ack_seen_ff;
		nxt_last_wr = last_wr_ff;
		nxt_fly_wr = fly_wr_ff;
		nxt_rdone = 1'b0;
		nxt_wdone = 1'b0;
		if (rd_valid && rd_ready)
		begin
			nxt_rp = 1'b1; nxt_ra = rd_addr; nxt_rc = rd_cs;
		end
		if (wr_valid && wr_ready)
		begin
			nxt_wp = 1'b1; nxt_wa = wr_addr; nxt_wc = wr_cs; nxt_wd = wr_data;
		end
		unique case (ax_st_ff)
			scc_pkg::AX_IDLE:
				if (rp_ff || wp_ff)
				begin
					nxt_fly_wr = pick_wr;
					nxt_last_wr = pick_wr;
					nxt_req_tgl = ~req_tgl_ff;
					nxt_ax_st = scc_pkg::AX_WAIT;
				end
			scc_pkg::AX_WAIT:
				if (ack_x.sync_lvl != ack_seen_ff)
				begin
					nxt_ack_seen = ack_x.sync_lvl;
					nxt_ax_st = scc_pkg::AX_IDLE;
					if (fly_wr_ff)
					begin
						nxt_wp = 1'b0;
						nxt_wdone = 1'b1;
					end
					else
					begin
						nxt_rp = 1'b0;
						nxt_rdone = 1'b1;
						nxt_rdat = mem_rdat_ff;
					end
				end
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (axi_rst)
		begin
			ax_st_ff <= scc_pkg::AX_IDLE;
			rp_ff <= 1'b0; ra_ff <= '0; rc_ff <= '0;
			wp_ff <= 1'b0; wa_ff <= '0; wc_ff <= '0; wd_ff <= '0;
			rdat_ff <= '0;
			req_tgl_ff <= 1'b0; ack_seen_ff <= 1'b0;
			last_wr_ff <= 1'b0; fly_wr_ff <= 1'b0;
			rdone_ff <= 1'b0; wdone_ff <= 1'b0;
		end
		else if (ce)
		begin
			ax_st_ff <= nxt_ax_st;
			rp_ff <= nxt_rp; ra_ff <= nxt_ra; rc_ff <= nxt_rc;
			wp_ff <= nxt_wp; wa_ff <= nxt_wa; wc_ff <= nxt_wc; wd_ff <= nxt_wd;
			rdat_ff <= nxt_rdat;
			req_tgl_ff <= nxt_req_tgl; ack_seen_ff <= nxt_ack_seen;
			last_wr_ff <= nxt_last_wr; fly_wr_ff <= nxt_fly_wr;
			rdone_ff <= nxt_rdone; wdone_ff <= nxt_wdone;
		end
	end

	assign req_x.lvl = req_tgl_ff;
	assign rd_done   = rdone_ff;
	assign wr_done   = wdone_ff;
	assign rd_data   = rdat_ff;

	// Memory domain: steps on each sampled rise of memory clock 0
	scc_pkg::scc_ms_state_t ms_st_ff, nxt_ms_st;
	logic                   mclk_prev_ff, tick;
	logic                   req_seen_ff, nxt_req_seen, ack_tgl_ff, nxt_ack_tgl;
	logic [3:0]             tick_cnt_ff, nxt_tick_cnt;
	logic [CS_COUNT-1:0]    cs_ff, nxt_cs;
	logic                   we_ff, nxt_we;
	logic [ADDR_W-1:0]      ma_ff, nxt_ma;
	logic [DATA_W-1:0]      mwd_ff, nxt_mwd;
	logic [1:0]             sel_cs;

	assign tick   = memory_clock_if0 & ~mclk_prev_ff;
	// selects beyond the configured count are dropped
	assign sel_cs = fly_wr_ff ? wc_ff : rc_ff;

	// Payload is stable in the AXI holding flops until the completion returns
	always_comb
	begin
		nxt_ms_st = ms_st_ff;
		nxt_req_seen = req_seen_ff;
		nxt_ack_tgl = ack_tgl_ff;
		nxt_tick_cnt = tick_cnt_ff;
		nxt_cs = cs_ff; nxt_we = we_ff; nxt_ma = ma_ff; nxt_mwd = mwd_ff;
		nxt_mem_rdat = mem_rdat_ff;
		if (tick)
		begin
			unique case (ms_st_ff)
				scc_pkg::MS_IDLE:
					if (req_x.sync_lvl != req_seen_ff)
					begin
						nxt_req_seen = req_x.sync_lvl;
						nxt_cs = '0;
						if (32'(sel_cs) < CS_COUNT)
							nxt_cs[sel_cs] = 1'b1;
						nxt_we = fly_wr_ff;
						nxt_ma = fly_wr_ff ? wa_ff : ra_ff;
						nxt_mwd = wd_ff;
						nxt_tick_cnt = scc_pkg::MEM_ACCESS_TICKS;
						nxt_ms_st = scc_pkg::MS_ACCESS;
					end
				scc_pkg::MS_ACCESS:
					if (tick_cnt_ff == 4'h1)
					begin
						nxt_mem_rdat = mem_rdata_if0;
						nxt_cs = '0;
						nxt_we = 1'b0;
						nxt_ack_tgl = ~ack_tgl_ff;
						nxt_ms_st = scc_pkg::MS_IDLE;
					end
					else
						nxt_tick_cnt = tick_cnt_ff - 4'h1;
			endcase
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (mem_rst)
		begin
			ms_st_ff <= scc_pkg::MS_IDLE;
			mclk_prev_ff <= 1'b0;
			req_seen_ff <= 1'b0; ack_tgl_ff <= 1'b0;
			tick_cnt_ff <= '0;
			cs_ff <= '0; we_ff <= 1'b0; ma_ff <= '0; mwd_ff <= '0;
			mem_rdat_ff <= '0;
		end
		else if (ce)
		begin
			ms_st_ff <= nxt_ms_st;
			mclk_prev_ff <= memory_clock_if0;
			req_seen_ff <= nxt_req_seen; ack_tgl_ff <= nxt_ack_tgl;
			tick_cnt_ff <= nxt_tick_cnt;
			cs_ff <= nxt_cs; we_ff <= nxt_we; ma_ff <= nxt_ma; mwd_ff <= nxt_mwd;
			mem_rdat_ff <= nxt_mem_rdat;
		end
	end

	assign ack_x.lvl     = ack_tgl_ff;
	assign mem_cs_if0    = cs_ff;
	assign mem_we_if0    = we_ff;
	assign mem_addr_if0  = ma_ff;
	assign mem_wdata_if0 = mwd_ff;

	// Configuration, direct command and test words (AXI domain)
	logic [scc_pkg::OPM_W-1:0]     opm_ff, nxt_opm;
	logic [1:0]                    new_mw;
	logic                          dci_ff, nxt_dci, dcg_ff, nxt_dcg;
	logic [scc_pkg::INT_OUT_W-1:0] iout_ff, nxt_iout;
	logic                          pair_ff, nxt_pair, lpack_ff, nxt_lpack;

	// NAND keeps only the width field
	// NAND width limited to 8 or 16
	always_comb
	begin
		new_mw = pending_opmode[scc_pkg::OPM_MW_LSB +: scc_pkg::OPM_MW_W];
		if (IF0_NAND)
			new_mw = {1'b0, new_mw[0]};
		nxt_opm = opm_ff;
		if (opmode_load)
		begin
			if (IF0_NAND)
			begin
				nxt_opm = scc_pkg::OPM_RESET;
				nxt_opm[scc_pkg::OPM_MW_LSB +: scc_pkg::OPM_MW_W] = new_mw;
			end
			else if (new_mw != scc_pkg::MW_RSVD)
				nxt_opm = pending_opmode;
		end
		nxt_dci = dcmd_valid & (!IF0_NAND || dcmd_type == scc_pkg::NAND_CMD_TYPE);
		nxt_dcg = dcmd_valid & ~nxt_dci;
		nxt_iout = iout_ff;
		if (int_out_wr)
			nxt_iout = int_out_wdata & scc_pkg::INT_OUT_IMPL_MASK;
		// clock and its copy must differ
		nxt_pair = (memory_clock_if0 == memory_clock_if0_inverted);
		nxt_lpack = lowpower_req & ~rp_ff & ~wp_ff;
	end

	always_ff @(posedge clk_sys)
	begin
		if (axi_rst)
		begin
			opm_ff <= scc_pkg::OPM_RESET;
			dci_ff <= 1'b0; dcg_ff <= 1'b0;
			iout_ff <= scc_pkg::INT_OUT_RESET;
			pair_ff <= 1'b0; lpack_ff <= 1'b0;
		end
		else if (ce)
		begin
			opm_ff <= nxt_opm;
			dci_ff <= nxt_dci; dcg_ff <= nxt_dcg;
			iout_ff <= nxt_iout;
			pair_ff <= nxt_pair; lpack_ff <= nxt_lpack;
		end
	end

	assign current_opmode       = opm_ff;
	assign current_memory_width = opm_ff[scc_pkg::OPM_MW_LSB +: scc_pkg::OPM_MW_W];
	assign dcmd_issued          = dci_ff;
	assign dcmd_ignored         = dcg_ff;
	assign clock_pair_fault_if0 = pair_ff;
	assign int_out_q            = iout_ff;

	assign int_in_rdata = {4'h0, mem_side_sync_ind_if0, axi_side_sync_ind_if0,
		ext_bus_backoff_if0, ext_bus_grant_if0, use_ext_bus, lowpower_req}
		& scc_pkg::INT_IN_IMPL_MASK;

	// Test mode drives activity, low-power ack, bus request and interrupt from the test word instead of the logic
	assign activity        = int_test_en ? iout_ff[scc_pkg::INT_OUT_ACTIVE]
		: (rp_ff | wp_ff);
	assign lowpower_ack    = int_test_en ? iout_ff[scc_pkg::INT_OUT_LP_ACK] : lpack_ff;
	assign ext_bus_req_if0 = int_test_en ? iout_ff[scc_pkg::INT_OUT_EBIREQ]
		: (use_ext_bus & (ax_st_ff == scc_pkg::AX_WAIT));
	assign mem_irq_if0     = int_test_en & iout_ff[scc_pkg::INT_OUT_IRQ0];
endmodule
`default_nettype wire

// >>> bench/scc_mem_model.sv
// Purpose: Memory clock source and read responder for interface 0
// Assumes: Memory clock is a divided copy of clk_sys
// Notes:   Released data shows the inverse of the last word, never a held copy
`timescale 1ns/1ps
`default_nettype none
module scc_mem_model (
	// Clock and rate
	input  wire logic        clk_sys,
	input  wire logic        slow,
	// Pads
	input  wire logic [3:0]  mem_cs_if0,
	input  wire logic [31:0] mem_addr_if0,
	output logic             memory_clock_if0,
	output logic             memory_clock_if0_inverted,
	output logic [31:0]      mem_rdata_if0
);
	logic [1:0]	div = 2'h0;
	initial memory_clock_if0 = 1'b0;
	initial mem_rdata_if0 = 32'h0;
	always @(posedge clk_sys)
	begin
		div <= (div == {slow, 1'b0}) ? 2'h0 : div + 2'h1;
		if (div == {slow, 1'b0})
			memory_clock_if0 <= !memory_clock_if0;
	end
	assign memory_clock_if0_inverted = !memory_clock_if0;
	// Unselected bus toggles so a late capture cannot pass by luck
	always @(posedge clk_sys)
		mem_rdata_if0 <= (|mem_cs_if0) ? mem_addr_if0 ^ 32'hc3a5_5a3c : ~mem_rdata_if0;
endmodule
`default_nettype wire

// >>> bench/scc_clock_config_chk.sv
// Purpose: Port-level assertions of the clock/config core
// Assumes: Default parameters, NAND interface
// Notes:   Held off until both release chains are full
`timescale 1ns/1ps
`default_nettype none
module scc_clock_config_chk (
	// Clock and resets
	input wire logic       clk_sys,
	input wire logic       rst,
	input wire logic       ce,
	input wire logic       axi_reset_low,
	input wire logic       memory_reset_if0_low,
	// Requests
	input wire logic       rd_valid,
	input wire logic       rd_ready,
	input wire logic       rd_done,
	input wire logic       dcmd_valid,
	input wire logic [1:0] dcmd_type,
	input wire logic       dcmd_issued,
	input wire logic       dcmd_ignored,
	input wire logic       opmode_load,
	input wire logic [7:0] pending_opmode,
	input wire logic [7:0] current_opmode,
	// Integration test
	input wire logic       int_test_en,
	input wire logic       int_out_wr,
	input wire logic [8:0] int_out_wdata,
	input wire logic [8:0] int_out_q,
	input wire logic       activity,
	input wire logic       lowpower_ack,
	input wire logic       ext_bus_req_if0,
	input wire logic       mem_irq_if0
);
	// Mirrors the two-edge release so checks skip the held period
	logic [1:0]	run_ff;
	logic [1:0]	nxt_run;
	logic		up;
	always_comb
	begin
		nxt_run = run_ff;
		if (rst || !axi_reset_low || !memory_reset_if0_low)
			nxt_run = 2'h0;
		else if (ce && run_ff != 2'h2)
			nxt_run = run_ff + 2'h1;
	end
	always_ff @(posedge clk_sys)
		run_ff <= nxt_run;
	assign up = (run_ff == 2'h2);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst || !up || !axi_reset_low || !memory_reset_if0_low);

	property p_dcmd_ok;
		ce && dcmd_valid && dcmd_type == 2'h2 |=> dcmd_issued && !dcmd_ignored;
	endproperty
	a_dcmd_ok: assert property (p_dcmd_ok)
		else $error("honoured command kind not issued");
	property p_dcmd_bad;
		ce && dcmd_valid && dcmd_type != 2'h2 |=> dcmd_ignored && !dcmd_issued;
	endproperty
	a_dcmd_bad: assert property (p_dcmd_bad)
		else $error("other command kind not ignored");
	property p_opm_one;
		ce && opmode_load && pending_opmode[0] |=> current_opmode == 8'h01;
	endproperty
	a_opm_one: assert property (p_opm_one)
		else $error("width bit one not stored alone");
	property p_opm_zero;
		ce && opmode_load && !pending_opmode[0] |=> current_opmode == 8'h00;
	endproperty
	a_opm_zero: assert property (p_opm_zero)
		else $error("width bit zero not stored alone");
	property p_opm_hold;
		!(ce && opmode_load) |=> $stable(current_opmode);
	endproperty
	a_opm_hold: assert property (p_opm_hold)
		else $error("configuration changed without load");
	property p_int_out;
		ce && int_out_wr |=> int_out_q == ($past(int_out_wdata) & 9'h027);
	endproperty
	a_int_out: assert property (p_int_out)
		else $error("integration output bits not masked");
	property p_test_mode;
		int_test_en |-> {mem_irq_if0, ext_bus_req_if0, lowpower_ack, activity}
			== {int_out_q[5], int_out_q[2:0]};
	endproperty
	a_test_mode: assert property (p_test_mode)
		else $error("test mode outputs differ from register");
	property p_rd_lat;
		ce && rd_valid && rd_ready |=> (!rd_ready && !rd_done) [*4] ##[1:1000] rd_done;
	endproperty
	a_rd_lat: assert property (p_rd_lat)
		else $error("read completion early or missing");
	property p_irq_off;
		!int_test_en |-> !mem_irq_if0;
	endproperty
	a_irq_off: assert property (p_irq_off)
		else $error("interface interrupt raised outside test mode");
endmodule
bind scc_clock_config scc_clock_config_chk u_chk (.*);
`default_nettype wire

// >>> bench/testbench.sv
// Purpose: Self-checking bench of the clock/config core
// Assumes: Default parameters; partner model gives memory clock and data
// Notes:   Random stimulus from a fixed seed, corners written by hand
`timescale 1ns/1ps
`default_nettype none
module testbench;
	// Clock, resets, tie-offs
	logic	clk_sys = 1'b0, rst = 1'b1, ce = 1'b1, slow = 1'b0;
	logic	axi_reset_low = 1'b1, memory_reset_if0_low = 1'b1;
	logic	axi_side_sync_ind_if0 = 1'b0, mem_side_sync_ind_if0 = 1'b0;
	logic	axi_faster_sync_if0 = 1'b0, lowpower_req = 1'b0, use_ext_bus = 1'b0;
	logic	ext_bus_grant_if0 = 1'b0, ext_bus_backoff_if0 = 1'b0;
	logic [1:0]	rw_priority = 2'h0, rd_cs = 2'h0, wr_cs = 2'h0, dcmd_type = 2'h0;
	// Requests and answers
	logic	rd_valid = 1'b0, wr_valid = 1'b0, dcmd_valid = 1'b0, opmode_load = 1'b0;
	logic [31:0]	rd_addr = 32'h0, wr_addr = 32'h0, wr_data = 32'h0;
	logic [7:0]	pending_opmode = 8'h00, current_opmode;
	logic	rd_ready, rd_done, wr_ready, wr_done, dcmd_issued, dcmd_ignored;
	logic [31:0]	rd_data, mem_addr_if0, mem_wdata_if0, mem_rdata_if0;
	logic [1:0]	current_memory_width;
	// Integration test and pads
	logic	int_test_en = 1'b0, int_out_wr = 1'b0;
	logic [8:0]	int_out_wdata = 9'h000, int_out_q;
	logic [9:0]	int_in_rdata;
	logic	activity, lowpower_ack, ext_bus_req_if0, mem_irq_if0;
	logic	clock_pair_fault_if0, mem_we_if0, memory_clock_if0, memory_clock_if0_inverted;
	logic [3:0]	mem_cs_if0, seen_cs;
	logic [31:0]	seen_wa, seen_wd;
	int	errors = 0, tests_run = 0, cyc = 0;

	scc_clock_config uut (.*);
	scc_mem_model u_mem (.*);

	always #2 clk_sys = ~clk_sys;

	// Last write seen on the pads, so a lost write payload cannot hide
	always @(posedge clk_sys)
		if (mem_we_if0 && |mem_cs_if0)
			{seen_cs, seen_wa, seen_wd} <= {mem_cs_if0, mem_addr_if0, mem_wdata_if0};

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (exp !== got)
		begin
			$display("ERROR %s expected %h seen %h", what, exp, got);
			errors++;
		end
	endtask

	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Hang guard: far beyond the slowest access sequence
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			errors++;
			give_verdict();
		end
	end

	// One read and/or write; valid drops on the edge that takes it
	task automatic rw(input bit dr, input bit dw);
		int trd;
		int twr;
		bit rr;
		bit wq;
		logic [31:0] ra;
		logic [31:0] wa;
		logic [31:0] wd;
		logic [1:0] wc;
		trd = -1;
		twr = -1;
		ra = $urandom;
		wa = $urandom;
		wd = $urandom;
		wc = 2'($urandom);
		@(posedge clk_sys);
		rd_valid <= dr;
		wr_valid <= dw;
		rd_addr <= ra;
		wr_addr <= wa;
		wr_data <= wd;
		rd_cs <= 2'($urandom);
		wr_cs <= wc;
		for (int n = 0; n < 1500 && ((dr && trd < 0) || (dw && twr < 0)); n++)
		begin
			#1;
			rr = rd_ready;
			wq = wr_ready;
			if (rd_done === 1'b1)
				trd = n;
			if (wr_done === 1'b1)
				twr = n;
			@(posedge clk_sys);
			if (rr)
				rd_valid <= 1'b0;
			if (wq)
				wr_valid <= 1'b0;
		end
		if (dr)
			chk("rd_data", ra ^ 32'hc3a5_5a3c, rd_data);
		if (dw)
		begin
			chk("wr_done seen", 32'h1, 32'(twr >= 0));
			chk("mem_addr_if0", wa, seen_wa);
			chk("mem_wdata_if0", wd, seen_wd);
			chk("mem_cs_if0", 32'(4'h1) << wc, 32'(seen_cs));
		end
		if (dr && dw && rw_priority != 2'h2)
			chk("read first", 32'(rw_priority != 2'h1), 32'(trd < twr));
	endtask

	initial
	begin
		logic [1:0] t;
		logic [1:0] nt;
		logic [7:0] np;
		logic [7:0] p;
		logic [7:0] e;
		logic [8:0] w;
		logic [5:0] v;
		void'($urandom(56851));
		t = 2'h0;
		p = 8'h00;
		e = 8'h00;
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (3) @(posedge clk_sys);
		#1 chk("clock_pair_fault_if0", 32'h0, 32'(clock_pair_fault_if0));
		// Back-to-back commands, every kind then random ones
		for (int i = 0; i < 13; i++)
		begin
			@(posedge clk_sys);
			nt = (i < 4) ? 2'(i) : 2'($urandom);
			dcmd_valid <= (i < 12);
			dcmd_type <= nt;
			#1;
			if (i > 0)
			begin
				chk("dcmd_issued", 32'(t == 2'h2), 32'(dcmd_issued));
				chk("dcmd_ignored", 32'(t != 2'h2), 32'(dcmd_ignored));
			end
			t = nt;
		end
		// Configuration loads; only the low width bit survives
		for (int i = 0; i < 9; i++)
		begin
			@(posedge clk_sys);
			np = (i == 0) ? 8'hff : (i == 5) ? 8'h01 : 8'($urandom);
			opmode_load <= (i < 6);
			pending_opmode <= np;
			#1;
			if (i > 0 && i < 7)
				e = {7'h00, p[0]};
			if (i > 0)
			begin
				chk("current_opmode", 32'(e), 32'(current_opmode));
				chk("current_memory_width", 32'(e[1:0]), 32'(current_memory_width));
			end
			p = np;
		end
		// AXI reset clears state and releases after two edges
		@(posedge clk_sys) axi_reset_low <= 1'b0;
		@(posedge clk_sys) axi_reset_low <= 1'b1;
		#1 chk("ready in reset", 32'h0, 32'(rd_ready));
		@(posedge clk_sys);
		#1 chk("ready in release", 32'h0, 32'(rd_ready));
		chk("opmode after reset", 32'h0, 32'(current_opmode));
		@(posedge clk_sys);
		#1 chk("ready released", 32'h1, 32'(rd_ready));
		// Integration outputs, half of them in test mode
		for (int i = 0; i < 6; i++)
		begin
			@(posedge clk_sys);
			w = (i == 0) ? 9'h1ff : 9'($urandom);
			int_out_wr <= 1'b1;
			int_out_wdata <= w;
			int_test_en <= i[0];
			@(posedge clk_sys);
			int_out_wr <= 1'b0;
			#1 chk("int_out_q", 32'(w & 9'h027), 32'(int_out_q));
			if (i[0])
				chk("test outputs", 32'({w[5], w[2:0]}),
					32'({mem_irq_if0, ext_bus_req_if0, lowpower_ack, activity}));
		end
		// A write while the enable is low must leave the word alone
		@(posedge clk_sys) {int_test_en, ce, int_out_wr, int_out_wdata} <= {3'b001, ~w};
		@(posedge clk_sys) {ce, int_out_wr} <= 2'b10;
		#1 chk("int_out_q frozen", 32'(w & 9'h027), 32'(int_out_q));
		// Integration inputs mirror the interface-0 tie-offs
		for (int i = 0; i < 8; i++)
		begin
			@(posedge clk_sys);
			v = 6'($urandom);
			{mem_side_sync_ind_if0, axi_side_sync_ind_if0, ext_bus_backoff_if0,
				ext_bus_grant_if0, use_ext_bus, lowpower_req} <= v;
			#1 chk("int_in_rdata", 32'({4'h0, v}), 32'(int_in_rdata));
		end
		@(posedge clk_sys);
		{use_ext_bus, ext_bus_grant_if0, ext_bus_backoff_if0, lowpower_req} <= 4'h0;
		// Accesses over all priorities and memory rates, random crossing modes
		for (int i = 0; i < 16; i++)
		begin
			@(posedge clk_sys);
			rw_priority <= 2'(i);
			{axi_faster_sync_if0, mem_side_sync_ind_if0, axi_side_sync_ind_if0} <= 3'($urandom);
			slow <= i[2];
			rw(i < 12, i < 8 || i >= 12);
		end
		@(posedge clk_sys) memory_reset_if0_low <= 1'b0;
		@(posedge clk_sys) memory_reset_if0_low <= 1'b1;
		rw(1'b1, 1'b1);
		give_verdict();
	end
endmodule
`default_nettype wire
